// File: dv/cbtd_chk.sv
`timescale 1ns/100ps
module cbtd_chk
(
  // Clock and reset
  input wire        clk,
  input wire        rst_b,
  // Register port
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata_ff,
  // Samples and results
  input wire        sample_valid,
  input wire        comp_done,
  input wire [11:0] button_state_ff,
  input wire [11:0] touch_event_ff,
  input wire [11:0] release_event_ff,
  input wire        irq_ff,
  input wire        comp_request_ff,
  input wire        comp_busy_ff
);
  reg [7:0] cfg_ff;
  // Local copy of the config byte, taken on the same edge as the design
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      cfg_ff <= 8'h30;
    else if (reg_wr && reg_addr == 8'h21)
      cfg_ff <= reg_wdata;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Two idle cycles after a read cover either read latency
  sequence s_rd(a);
    reg_rd && reg_addr == a ##1 !reg_rd [*2];
  endsequence
  sequence s_irq_cause;
    (cfg_ff[4] && |touch_event_ff) || (cfg_ff[5] && |release_event_ff);
  endsequence
  property p_touch_state; (touch_event_ff & ~button_state_ff) == 12'h000;
  endproperty
  a_touch_state: assert property (p_touch_state)
    else $error("touch event on untouched input");
  property p_rel_state; (release_event_ff & button_state_ff) == 12'h000;
  endproperty
  a_rel_state: assert property (p_rel_state)
    else $error("release event on touched input");
  property p_touch_origin; |touch_event_ff |-> $past(sample_valid, 2);
  endproperty
  a_touch_origin: assert property (p_touch_origin)
    else $error("touch event without sample");
  property p_state_rise;
    |(button_state_ff & ~$past(button_state_ff)) |-> $past(sample_valid, 2);
  endproperty
  a_state_rise: assert property (p_state_rise)
    else $error("touch state rose without sample");
  property p_irq_cause; irq_ff |-> s_irq_cause; endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without selected event");
  property p_irq_need; s_irq_cause |-> irq_ff; endproperty
  a_irq_need: assert property (p_irq_need)
    else $error("selected event without interrupt");
  property p_req_busy; comp_request_ff |-> ##[0:1] comp_busy_ff; endproperty
  a_req_busy: assert property (p_req_busy)
    else $error("compensation launch without busy");
  property p_busy_hold; comp_busy_ff && !comp_done |=> comp_busy_ff;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped before done");
  property p_hyst_rd; s_rd(8'h25) |-> reg_rdata_ff <= 8'h64; endproperty
  a_hyst_rd: assert property (p_hyst_rd)
    else $error("hysteresis above limit");
endmodule

// File: dv/cbtd_host_model.sv
`timescale 1ns/100ps
module cbtd_host_model
(
  // Clock
  input  wire       clk,
  // Register port
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata_ff
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse so stale values never look valid
  task wr(input [7:0] a, input [7:0] d);
  begin
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge clk);
    #1 d = reg_rdata_ff;
    @(posedge clk);
    #1;
  end
  endtask
  task set_neg_limit_one;
    wr(8'h24, 8'h01);
  endtask
endmodule

// File: dv/cbtd_tb.sv
`timescale 1ns/100ps
module testbench;
  localparam [47:0] RSTV = {8'h00, 8'h0a, 8'h01, 8'h50, 8'h50, 8'h30};
  reg          clk, rst_b, sld_rel, sample_valid, comp_done;
  reg  [95:0]  lvl;
  reg  [3:0]   per;
  reg  [191:0] tick, avg;
  reg  [7:0]   rv;
  wire         reg_wr, reg_rd, irq, creq, busy;
  wire [7:0]   reg_addr, reg_wdata, reg_rdata_ff;
  wire [11:0]  state, tevt, revt, susp;
  integer      err_total, checks, ncomp, n0, i, k, w;
  cbtd_top #(.SEC_CYC(100)) u_cbtd_top
  (
    .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .sensor_touch_level(lvl),
    .periodic_recal_interval(per), .slider_released(sld_rel),
    .sample_valid(sample_valid), .sense_input_ticks(tick),
    .sense_input_average(avg), .comp_done(comp_done),
    .button_state_ff(state), .touch_event_ff(tevt),
    .release_event_ff(revt), .irq_ff(irq), .avg_suspend_ff(susp),
    .comp_request_ff(creq), .comp_busy_ff(busy)
  );
  cbtd_host_model host
  (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff)
  );
  always #12.5 clk = ~clk;
  // Compensation engine stand-in answers one cycle after launch
  always @(posedge clk)
  begin
    comp_done <= #1 (creq === 1'b1);
    if (!rst_b)
      ncomp <= 0;
    else if (creq === 1'b1)
      ncomp <= ncomp + 1;
  end
  task check(input [31:0] seen, input [31:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // Events stand one cycle, from the edge after the sample edge
  task samp(input integer ch, input integer t);
  begin
    tick[ch*16 +: 16] = t[15:0];
    sample_valid = 1'b1;
    @(posedge clk);
    #1 sample_valid = 1'b0;
    @(posedge clk);
    #1;
  end
  endtask
  task settle;
  begin
    repeat (4) @(posedge clk);
    #1;
  end
  endtask
  task wait_comp(input integer lim);
  begin
    n0 = ncomp;
    w = 0;
    while (ncomp == n0 && w < lim)
    begin
      @(posedge clk);
      w = w + 1;
    end
    #1;
    if (ncomp == n0)
    begin
      err_total = err_total + 1;
      results;
    end
  end
  endtask
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    sld_rel = 1'b1;
    sample_valid = 1'b0;
    lvl = {12{8'h64}};
    lvl[15:8] = 8'h6f;
    per = 4'h0;
    tick = 192'h0;
    avg = 192'h0;
    err_total = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    settle;
    for (i = 0; i < 6; i = i + 1)
    begin
      host.rd(8'h21 + i[7:0], rv);
      check(rv, RSTV[i*8 +: 8]);
    end
    host.rd(8'h27, rv);
    check(rv, 8'h00);
    host.wr(8'h25, 8'h70);
    host.rd(8'h25, rv);
    check(rv, 8'h64);
    host.wr(8'h25, 8'h0a);
    $display("test registers done");
    samp(0, 110);
    check(state, 12'h000);
    samp(0, 111);
    check({irq, tevt}, 13'h1001);
    samp(1, 122);
    check(state, 12'h001);
    samp(1, 123);
    check(state, 12'h003);
    samp(1, 100);
    check(state, 12'h003);
    samp(1, 99);
    check({irq, revt}, 13'h1002);
    samp(0, 90);
    check(state, 12'h001);
    samp(0, 89);
    check(revt, 12'h001);
    $display("test hysteresis done");
    for (k = 0; k < 4; k = k + 1)
    begin
      host.wr(8'h21, 8'h30 | k[7:0] | (k[7:0] << 2));
      for (i = 0; i < k; i = i + 1)
      begin
        samp(0, 200);
        check(state[0], 1'b0);
      end
      samp(0, 200);
      check(tevt, 12'h001);
      for (i = 0; i < k; i = i + 1)
      begin
        samp(0, 0);
        check(state[0], 1'b1);
      end
      samp(0, 0);
      check(revt, 12'h001);
    end
    for (k = 0; k < 4; k = k + 1)
    begin
      host.wr(8'h21, {2'b00, k[1:0], 4'h0});
      samp(0, 200);
      check({irq, tevt[0]}, {k[0], 1'b1});
      samp(0, 0);
      check({irq, revt[0]}, {k[1], 1'b1});
    end
    $display("test debounce done");
    host.wr(8'h21, 8'h70);
    samp(0, 200);
    check(tevt, 12'h001);
    samp(1, 200);
    check(tevt, 12'h000);
    samp(1, 0);
    check(revt, 12'h000);
    samp(0, 0);
    check(revt, 12'h001);
    samp(2, 200);
    check(tevt, 12'h004);
    samp(2, 0);
    host.wr(8'h21, 8'h30);
    $display("test single done");
    avg[15:0] = 16'd319;
    samp(0, 0);
    check(susp, 12'h000);
    avg[15:0] = 16'd320;
    avg[31:16] = 16'd320;
    n0 = ncomp;
    samp(0, 0);
    settle;
    check(susp, 12'h003);
    check(ncomp, n0);
    avg[47:32] = 16'd320;
    samp(0, 0);
    settle;
    check(ncomp > n0, 1'b1);
    avg = 192'h0;
    samp(0, 0);
    host.wr(8'h24, 8'h02);
    n0 = ncomp;
    samp(3, -321);
    settle;
    check(ncomp, n0);
    samp(3, -321);
    settle;
    check(ncomp > n0, 1'b1);
    host.set_neg_limit_one;
    n0 = ncomp;
    samp(3, -320);
    settle;
    check(ncomp, n0);
    samp(3, -321);
    settle;
    check(ncomp > n0, 1'b1);
    samp(3, 0);
    settle;
    $display("test compensation done");
    host.wr(8'h26, 8'h01);
    samp(0, 200);
    check(state[0], 1'b1);
    wait_comp(400);
    settle;
    check(state[0], 1'b0);
    samp(0, 200);
    check(state[0], 1'b0);
    samp(0, 0);
    samp(0, 200);
    check(tevt, 12'h001);
    host.wr(8'h26, 8'h00);
    samp(0, 0);
    $display("test stuck done");
    per = 4'h1;
    wait_comp(400);
    wait_comp(400);
    check(w >= 95 && w <= 105, 1'b1);
    per = 4'h8;
    wait_comp(2000);
    wait_comp(2000);
    check(w >= 1590 && w <= 1610, 1'b1);
    sld_rel = 1'b0;
    per = 4'h1;
    settle;
    n0 = ncomp;
    repeat (300) @(posedge clk);
    #1;
    check(ncomp, n0);
    $display("test periodic done");
    results;
  end
endmodule
bind cbtd_top cbtd_chk u_cbtd_chk
(
  .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_ff(reg_rdata_ff), .sample_valid(sample_valid),
  .comp_done(comp_done), .button_state_ff(button_state_ff),
  .touch_event_ff(touch_event_ff), .release_event_ff(release_event_ff),
  .irq_ff(irq_ff), .comp_request_ff(comp_request_ff),
  .comp_busy_ff(comp_busy_ff)
);

// File: inc/cbtd_regs.vh
`ifndef CBTD_REGS_VH
`define CBTD_REGS_VH
`define CBTD_NCH            12
`define CBTD_TW             16
`define CBTD_ADR_CFG        8'h21
`define CBTD_ADR_AVG        8'h22
`define CBTD_ADR_NEG        8'h23
`define CBTD_ADR_NCNT       8'h24
`define CBTD_ADR_HYST       8'h25
`define CBTD_ADR_STUCK      8'h26
`define CBTD_RST_CFG        8'h30
`define CBTD_RST_AVG        8'h50
`define CBTD_RST_NEG        8'h50
`define CBTD_RST_NCNT       8'h01
`define CBTD_RST_HYST       8'h0a
`define CBTD_RST_STUCK      8'h00
`define CBTD_F_MODE_HI      7
`define CBTD_F_MODE_LO      6
`define CBTD_F_IRQ_HI       5
`define CBTD_F_IRQ_LO       4
`define CBTD_F_RDB_HI       3
`define CBTD_F_RDB_LO       2
`define CBTD_F_TDB_HI       1
`define CBTD_F_TDB_LO       0
`define CBTD_HYST_MAX       8'h64
`define CBTD_CLK_HZ         40000000
`define CBTD_SEC_CYC        (`CBTD_CLK_HZ)
`define CBTD_AVG_MIN_HITS   4'd3
`endif

// File: rtl/cbtd_chan.v
`timescale 1ns/100ps
`include "cbtd_regs.vh"
module cbtd_chan
(
  // Clock and reset
  input  wire                     clk,
  input  wire                     rst_sync_b,
  // Sample
  input  wire                     sample_valid,
  input  wire signed [15:0]       ticks,
  input  wire signed [15:0]       average,
  input  wire [7:0]               thresh,
  // Configuration
  input  wire [7:0]               hyst_pct,
  input  wire [1:0]               tdb_sel,
  input  wire [1:0]               rdb_sel,
  input  wire [9:0]               avg_level,
  input  wire [9:0]               neg_level,
  input  wire [7:0]               neg_limit,
  // Control
  input  wire                     force_release,
  input  wire                     comp_clear,
  // State
  output reg                      touched_ff,
  output reg                      hold_ff,
  output wire                     avg_hit,
  output reg                      neg_trig_ff,
  output reg                      touch_evt_ff,
  output reg                      rel_evt_ff
);
  reg  [1:0]  db_ff;
  reg  [7:0]  ncnt_ff;
  wire [15:0] hyst_amt;
  wire signed [17:0] up_lvl;
  wire signed [17:0] dn_lvl;
  wire        want_touch;
  wire        want_rel;
  wire        is_neg;
  // Threshold times percent, truncated
  assign hyst_amt = (({8'h0, thresh} * {8'h0, hyst_pct}) / 16'd100);
  assign up_lvl = $signed({2'b00, 8'h0, thresh}) +
                  $signed({2'b00, hyst_amt});
  assign dn_lvl = $signed({2'b00, 8'h0, thresh}) -
                  $signed({2'b00, hyst_amt});
  assign want_touch = ($signed({{2{ticks[15]}}, ticks}) > up_lvl);
  assign want_rel   = ($signed({{2{ticks[15]}}, ticks}) < dn_lvl);
  assign avg_hit = ($signed({{2{average[15]}}, average}) >=
                    $signed({8'h0, avg_level}));
  assign is_neg  = ($signed({{2{ticks[15]}}, ticks}) <
                    -$signed({8'h0, neg_level}));
  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      db_ff        <= 2'd0;
      ncnt_ff      <= 8'h0;
      touched_ff   <= 1'b0;
      hold_ff      <= 1'b0;
      neg_trig_ff  <= 1'b0;
      touch_evt_ff <= 1'b0;
      rel_evt_ff   <= 1'b0;
    end
    else
    begin
      touch_evt_ff <= 1'b0;
      rel_evt_ff   <= 1'b0;
      neg_trig_ff  <= 1'b0;
      if (comp_clear)
        ncnt_ff <= 8'h0;
      if (force_release && touched_ff)
      begin
        // Stuck touch: report release, wait for a real lift
        touched_ff <= 1'b0;
        hold_ff    <= 1'b1;
        rel_evt_ff <= 1'b1;
        db_ff      <= 2'd0;
      end
      else if (sample_valid)
      begin
        if (is_neg && !comp_clear)
        begin
          if (ncnt_ff + 8'h1 >= neg_limit)
          begin
            neg_trig_ff <= 1'b1;
            ncnt_ff     <= 8'h0;
          end
          else
            ncnt_ff <= ncnt_ff + 8'h1;
        end
        if (hold_ff)
        begin
          if (!want_touch)
            hold_ff <= 1'b0;
        end
        else if (!touched_ff)
        begin
          if (!want_touch)
            db_ff <= 2'd0;
          else if (db_ff >= tdb_sel)
          begin
            touched_ff   <= 1'b1;
            touch_evt_ff <= 1'b1;
            db_ff        <= 2'd0;
          end
          else
            db_ff <= db_ff + 2'd1;
        end
        else
        begin
          if (!want_rel)
            db_ff <= 2'd0;
          else if (db_ff >= rdb_sel)
          begin
            touched_ff <= 1'b0;
            rel_evt_ff <= 1'b1;
            db_ff      <= 2'd0;
          end
          else
            db_ff <= db_ff + 2'd1;
        end
      end
    end
  end
endmodule

// File: rtl/cbtd_tick_timer.v
`timescale 1ns/100ps
`include "cbtd_regs.vh"
module cbtd_tick_timer
#(
  parameter SEC_CYC = `CBTD_SEC_CYC
)
(
  // Clock and reset
  input  wire       clk,
  input  wire       rst_sync_b,
  // One-second strobe
  output reg        sec_pulse_ff
);
  reg [31:0] cnt_ff;
  wire       wrap;
  assign wrap = (cnt_ff == SEC_CYC - 1);
  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      cnt_ff       <= 32'h0;
      sec_pulse_ff <= 1'b0;
    end
    else
    begin
      cnt_ff       <= wrap ? 32'h0 : cnt_ff + 32'h1;
      sec_pulse_ff <= wrap;
    end
  end
endmodule

// File: rtl/cbtd_top.v
`timescale 1ns/100ps
`include "cbtd_regs.vh"
module cbtd_top
#(
  parameter SEC_CYC = `CBTD_SEC_CYC
)
(
  // Clock and reset
  input  wire         clk,
  input  wire         rst_b,
  // Register port (byte wide, from serial slave)
  input  wire         reg_wr,
  input  wire         reg_rd,
  input  wire [7:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  output reg  [7:0]   reg_rdata_ff,
  // Per-input configuration from other register groups
  input  wire [95:0]  sensor_touch_level,
  input  wire [3:0]   periodic_recal_interval,
  input  wire         slider_released,
  // Scan samples, one strobe per scan period
  input  wire         sample_valid,
  input  wire [191:0] sense_input_ticks,
  input  wire [191:0] sense_input_average,
  input  wire         comp_done,
  // Results
  output reg  [11:0]  button_state_ff,
  output reg  [11:0]  touch_event_ff,
  output reg  [11:0]  release_event_ff,
  output reg          irq_ff,
  output reg  [11:0]  avg_suspend_ff,
  output reg          comp_request_ff,
  output reg          comp_busy_ff
);
  localparam ST_IDLE = 1'b0;
  localparam ST_COMP = 1'b1;

  reg         rst_m_ff;
  reg         rst_sync_b;
  reg  [7:0]  cfg_ff;
  reg  [7:0]  avg_ff;
  reg  [7:0]  neg_ff;
  reg  [7:0]  ncnt_ff;
  reg  [7:0]  hyst_ff;
  reg  [7:0]  stuck_ff;
  reg         state_ff;
  reg  [3:0]  owner_ff;
  reg         owner_vld_ff;
  reg  [7:0]  stuck_cnt_ff;
  reg  [5:0]  per_cnt_ff;
  reg  [7:0]  nxt_rdata;
  reg  [5:0]  per_secs;
  reg  [3:0]  hit_cnt;
  reg  [11:0] tev_m;
  reg  [11:0] rev_m;
  reg         nxt_irq;
  reg  [3:0]  first_idx;
  reg         first_vld;
  integer     k;

  wire        sec_pulse;
  wire [11:0] touched;
  wire [11:0] hold;
  wire [11:0] avg_hit;
  wire [11:0] neg_trig;
  wire [11:0] tev;
  wire [11:0] rev;
  wire        force_rel;
  wire        all_rel;
  wire        comp_start;
  wire        stuck_hit;
  wire        per_hit;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_m_ff   <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_m_ff   <= 1'b1;
      rst_sync_b <= rst_m_ff;
    end
  end

  cbtd_tick_timer #(.SEC_CYC(SEC_CYC)) u_sec
  (
    .clk          (clk),
    .rst_sync_b   (rst_sync_b),
    .sec_pulse_ff (sec_pulse)
  );

  genvar g;
  generate
    for (g = 0; g < `CBTD_NCH; g = g + 1)
    begin : g_ch
      // Proximity inputs use the same path
      cbtd_chan u_ch
      (
        .clk           (clk),
        .rst_sync_b    (rst_sync_b),
        .sample_valid  (sample_valid && state_ff == ST_IDLE),
        .ticks         (sense_input_ticks[16*g +: 16]),
        .average       (sense_input_average[16*g +: 16]),
        .thresh        (sensor_touch_level[8*g +: 8]),
        .hyst_pct      (hyst_ff),
        .tdb_sel       (cfg_ff[`CBTD_F_TDB_HI:`CBTD_F_TDB_LO]),
        .rdb_sel       (cfg_ff[`CBTD_F_RDB_HI:`CBTD_F_RDB_LO]),
        .avg_level     ({avg_ff, 2'b00}),
        .neg_level     ({neg_ff, 2'b00}),
        .neg_limit     (ncnt_ff),
        .force_release (force_rel),
        .comp_clear    (comp_start),
        .touched_ff    (touched[g]),
        .hold_ff       (hold[g]),
        .avg_hit       (avg_hit[g]),
        .neg_trig_ff   (neg_trig[g]),
        .touch_evt_ff  (tev[g]),
        .rel_evt_ff    (rev[g])
      );
    end
  endgenerate

  // Register reads
  always @*
  begin
    case (reg_addr)
      `CBTD_ADR_CFG:   nxt_rdata = cfg_ff;
      `CBTD_ADR_AVG:   nxt_rdata = avg_ff;
      `CBTD_ADR_NEG:   nxt_rdata = neg_ff;
      `CBTD_ADR_NCNT:  nxt_rdata = ncnt_ff;
      `CBTD_ADR_HYST:  nxt_rdata = hyst_ff;
      `CBTD_ADR_STUCK: nxt_rdata = stuck_ff;
      default:         nxt_rdata = 8'h00;
    endcase
  end

  always @*
  begin
    case (periodic_recal_interval)
      4'h8:    per_secs = 6'd16;
      4'h9:    per_secs = 6'd18;
      4'ha:    per_secs = 6'd20;
      4'hb:    per_secs = 6'd22;
      4'hc:    per_secs = 6'd24;
      4'hd:    per_secs = 6'd26;
      4'he:    per_secs = 6'd28;
      4'hf:    per_secs = 6'd60;
      default: per_secs = {2'b00, periodic_recal_interval};
    endcase
  end

  always @*
  begin
    hit_cnt   = 4'd0;
    first_idx = 4'd0;
    first_vld = 1'b0;
    for (k = 0; k < `CBTD_NCH; k = k + 1)
    begin
      hit_cnt = hit_cnt + {3'b000, avg_hit[k]};
      if (tev[k] && !first_vld)
      begin
        first_idx = k[3:0];
        first_vld = 1'b1;
      end
    end
  end

  // Single mode forwards only the owner's events
  always @*
  begin
    if (cfg_ff[`CBTD_F_MODE_HI:`CBTD_F_MODE_LO] == 2'b01)
    begin
      tev_m = 12'h000;
      rev_m = 12'h000;
      if (!owner_vld_ff && first_vld)
        tev_m[first_idx] = 1'b1;
      if (owner_vld_ff)
        rev_m[owner_ff] = rev[owner_ff];
    end
    else
    begin
      tev_m = tev;
      rev_m = rev;
    end
    nxt_irq = (cfg_ff[`CBTD_F_IRQ_LO] && |tev_m) ||
              (cfg_ff[`CBTD_F_IRQ_HI] && |rev_m);
  end

  assign all_rel   = ~|touched && slider_released;
  // Whole seconds only, so the touch that started the count lasts the full timeout; later touches are released with it
  assign stuck_hit = (stuck_ff != 8'h00) && sec_pulse &&
                     (state_ff == ST_IDLE) &&
                     (stuck_cnt_ff >= stuck_ff);
  assign force_rel = stuck_hit;
  assign per_hit   = (per_secs != 6'd0) && sec_pulse && all_rel &&
                     (per_cnt_ff + 6'd1 >= per_secs);
  assign comp_start = (state_ff == ST_IDLE) &&
                      ((hit_cnt >= `CBTD_AVG_MIN_HITS) ||
                       |neg_trig || stuck_hit || per_hit);

  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      cfg_ff           <= `CBTD_RST_CFG;
      avg_ff           <= `CBTD_RST_AVG;
      neg_ff           <= `CBTD_RST_NEG;
      ncnt_ff          <= `CBTD_RST_NCNT;
      hyst_ff          <= `CBTD_RST_HYST;
      stuck_ff         <= `CBTD_RST_STUCK;
      reg_rdata_ff     <= 8'h00;
    end
    else
    begin
      if (reg_rd)
        reg_rdata_ff <= nxt_rdata;
      if (reg_wr)
      begin
        case (reg_addr)
          `CBTD_ADR_CFG:   cfg_ff   <= reg_wdata;
          `CBTD_ADR_AVG:   avg_ff   <= reg_wdata;
          `CBTD_ADR_NEG:   neg_ff   <= reg_wdata;
          `CBTD_ADR_NCNT:  ncnt_ff  <= reg_wdata;
          // Values above 100 percent are clamped
          `CBTD_ADR_HYST:  hyst_ff  <= (reg_wdata > `CBTD_HYST_MAX) ?
                                       `CBTD_HYST_MAX : reg_wdata;
          `CBTD_ADR_STUCK: stuck_ff <= reg_wdata;
          default:         ;
        endcase
      end
    end
  end

  // Owner tracking, timers and compensation sequencing
  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state_ff         <= ST_IDLE;
      owner_ff         <= 4'd0;
      owner_vld_ff     <= 1'b0;
      stuck_cnt_ff     <= 8'h00;
      per_cnt_ff       <= 6'd0;
    end
    else
    begin
      if (cfg_ff[`CBTD_F_MODE_HI:`CBTD_F_MODE_LO] != 2'b01)
        owner_vld_ff <= 1'b0;
      else if (!owner_vld_ff && first_vld)
      begin
        owner_vld_ff <= 1'b1;
        owner_ff     <= first_idx;
      end
      else if (owner_vld_ff && !touched[owner_ff])
        owner_vld_ff <= 1'b0;
      // Stuck timer runs while any button is held
      if (~|touched || stuck_hit)
        stuck_cnt_ff <= 8'h00;
      else if (sec_pulse)
        stuck_cnt_ff <= stuck_cnt_ff + 8'h1;
      if (!all_rel || per_hit || comp_start)
        per_cnt_ff <= 6'd0;
      else if (sec_pulse)
        per_cnt_ff <= per_cnt_ff + 6'd1;
      case (state_ff)
        ST_IDLE:
        begin
          if (comp_start)
            state_ff <= ST_COMP;
        end
        ST_COMP:
        begin
          if (comp_done)
            state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Every result leaves through a flop
  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      button_state_ff  <= 12'h000;
      touch_event_ff   <= 12'h000;
      release_event_ff <= 12'h000;
      irq_ff           <= 1'b0;
      avg_suspend_ff   <= 12'h000;
      comp_request_ff  <= 1'b0;
      comp_busy_ff     <= 1'b0;
    end
    else
    begin
      comp_request_ff  <= comp_start;
      comp_busy_ff     <= (state_ff == ST_COMP && !comp_done) || comp_start;
      avg_suspend_ff   <= avg_hit;
      button_state_ff  <= touched & ~hold;
      touch_event_ff   <= tev_m;
      release_event_ff <= rev_m;
      irq_ff           <= nxt_irq;
    end
  end
endmodule
